// file: hw/fpd_pkg.sv
`default_nettype none

package fpd_pkg;

  // system clock
  localparam int unsigned CLK_NS      = 5;
  // host bus word slot and derived cycle count
  localparam int unsigned WORD_NS     = 375;
  localparam int unsigned WORD_CLKS   = WORD_NS / CLK_NS;
  // controller clock period (8 MHz) and local clock (4 MHz, 250 ns)
  localparam int unsigned SCB_CLK_NS  = 125;
  localparam int unsigned SCB_DIV     = SCB_CLK_NS / CLK_NS;
  localparam int unsigned LOC_CLK_NS  = 250;
  localparam int unsigned LOC_DIV     = LOC_CLK_NS / SCB_CLK_NS;

  // sizes
  localparam int unsigned FIFO_BYTES  = 16;
  localparam int unsigned HOST_AW     = 24;
  localparam int unsigned REG_W       = 8;

  // phases inside one word slot
  localparam logic [6:0] PH_SETUP     = 7'h00;
  localparam logic [6:0] PH_DONE      = 7'(WORD_CLKS - 2);
  localparam logic [6:0] PH_LAST      = 7'(WORD_CLKS - 1);

  // register offsets
  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_ADDR0    = 8'h01;
  localparam logic [7:0] REG_ADDR1    = 8'h02;
  localparam logic [7:0] REG_ADDR2    = 8'h03;
  localparam logic [7:0] REG_CNT0     = 8'h04;
  localparam logic [7:0] REG_CNT1     = 8'h05;
  localparam logic [7:0] REG_CNT2     = 8'h06;
  localparam logic [7:0] REG_ON       = 8'h07;
  localparam logic [7:0] REG_OFF      = 8'h08;
  localparam logic [7:0] REG_STAT     = 8'h09;
  localparam logic [7:0] REG_FIFO     = 8'h0A;

  // control fields
  localparam int unsigned CTRL_START  = 0;
  localparam int unsigned CTRL_DIR    = 1;
  localparam int unsigned CTRL_WORD   = 2;
  localparam int unsigned CTRL_SRC    = 3;

  // reset values and tick counter limit
  localparam logic [7:0] RST_ON       = 8'h10;
  localparam logic [7:0] RST_OFF      = 8'h10;
  localparam logic [7:0] TCNT_MAX     = 8'hFF;

  // engine states, gray along idle-wait-request-transfer-off
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_WAIT = 3'h1,
    ST_REQ  = 3'h3,
    ST_XFER = 3'h2,
    ST_OFF  = 3'h6
  } fpd_state_e;

endpackage

`default_nettype wire

// file: hw/fpd_clk_div.sv
`default_nettype none

module fpd_clk_div
  import fpd_pkg::*;
#(
  parameter int unsigned DIV = fpd_pkg::SCB_DIV
) (
  // clock and reset
  input  wire logic i_clk_sys,
  input  wire logic i_sys_rst,
  // derived rates
  output var  logic o_loc_clk,
  output var  logic o_loc_tick
);

  // refuse a divider that the 8-bit counter cannot hold
  if (DIV < 2 || DIV > 255) begin : g_bad_div
    $error("fpd_clk_div: DIV out of range");
  end

  typedef struct packed {
    logic [7:0] cnt;
    logic       loc_clk;
    logic       loc_tick;
  } fpd_div_s;

  fpd_div_s st_reg, st_next;

  // 8 MHz enable, halved into the 4 MHz local clock
  always_comb begin
    st_next          = st_reg;
    st_next.loc_tick = 1'b0;
    if (st_reg.cnt == 8'(DIV - 1)) begin
      st_next.cnt     = 8'h00;
      st_next.loc_clk = ~st_reg.loc_clk;
      st_next.loc_tick = ~st_reg.loc_clk;
    end else begin
      st_next.cnt = st_reg.cnt + 8'h01;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_loc_clk  = st_reg.loc_clk;
  assign o_loc_tick = st_reg.loc_tick;

endmodule // fpd_clk_div

`default_nettype wire

// file: hw/fpd_fifo.sv
`default_nettype none

module fpd_fifo
  import fpd_pkg::*;
#(
  parameter int unsigned DEPTH = fpd_pkg::FIFO_BYTES,
  localparam int unsigned PW   = $clog2(DEPTH)
) (
  // clock and reset
  input  wire logic          i_clk_sys,
  input  wire logic          i_sys_rst,
  // write side, zero to two bytes, low byte first
  input  wire logic [1:0]    i_push_n,
  input  wire logic [15:0]   i_push_data,
  // read side, zero to two bytes
  input  wire logic [1:0]    i_pop_n,
  output var  logic [15:0]   o_head,
  output var  logic [PW:0]   o_level
);

  // pointers wrap only for a power-of-two depth
  if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_bad_depth
    $error("fpd_fifo: DEPTH not a power of two");
  end

  typedef struct packed {
    logic [DEPTH-1:0][7:0] mem;
    logic [PW-1:0]         rd;
    logic [PW-1:0]         wr;
    logic [PW:0]           lvl;
  } fpd_fifo_s;

  fpd_fifo_s st_reg, st_next;

  // byte storage with pointer wrap
  always_comb begin
    st_next = st_reg;
    if (i_push_n != 2'd0) begin
      st_next.mem[st_reg.wr] = i_push_data[7:0];
    end
    if (i_push_n == 2'd2) begin
      st_next.mem[st_reg.wr + PW'(1)] = i_push_data[15:8];
    end
    st_next.wr  = st_reg.wr + PW'(i_push_n);
    st_next.rd  = st_reg.rd + PW'(i_pop_n);
    st_next.lvl = st_reg.lvl + (PW + 1)'(i_push_n) - (PW + 1)'(i_pop_n);
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_head  = {st_reg.mem[st_reg.rd + PW'(1)], st_reg.mem[st_reg.rd]};
  assign o_level = st_reg.lvl;

endmodule // fpd_fifo

`default_nettype wire

// file: hw/fpd_dma.sv
// Local design decisions: the placing of the registers and strobed register access.
`default_nettype none

module fpd_dma
  import fpd_pkg::*;
#(
  parameter int unsigned FIFO_DEPTH = fpd_pkg::FIFO_BYTES
) (
  // clock and reset
  input  wire logic                     i_clk_sys,
  input  wire logic                     i_sys_rst,
  // local processor register port
  input  wire logic [7:0]               i_reg_addr,
  input  wire logic [fpd_pkg::REG_W-1:0] i_reg_wdata,
  input  wire logic                     i_reg_wr,
  input  wire logic                     i_reg_rd,
  output var  logic [fpd_pkg::REG_W-1:0] o_reg_rdata,
  // host expansion bus
  output var  logic                     o_host_drq,
  input  wire logic                     i_host_dack_n,
  output var  logic                     o_host_master_n,
  output var  logic [fpd_pkg::HOST_AW-1:0] o_host_addr,
  output var  logic                     o_host_sbhe_n,
  output var  logic                     o_host_memr_n,
  output var  logic                     o_host_memw_n,
  input  wire logic [15:0]              i_host_data,
  output var  logic [15:0]              o_host_data,
  output var  logic                     o_host_data_oe_n,
  // scsi bus controller byte handshake
  input  wire logic                     i_scb_req,
  input  wire logic [7:0]               i_scb_data,
  output var  logic [7:0]               o_scb_data,
  output var  logic                     o_scb_ack,
  // local processor clock
  output var  logic                     o_loc_clk
);

  if (FIFO_DEPTH != FIFO_BYTES) begin : g_bad_depth
    $error("fpd_dma: FIFO_DEPTH must be 16");
  end

  localparam int unsigned LW = $clog2(FIFO_DEPTH) + 1;
  localparam logic [LW-1:0] LVL_FULL = LW'(FIFO_DEPTH);
  localparam logic [LW-1:0] LVL_TWO  = LW'(2);

  typedef struct packed {
    fpd_state_e  st;
    logic [6:0]  ph;
    logic        dir;       // 1 = toward host
    logic        word_mode;
    logic        src;       // 1 = processor feeds or drains fifo, 0 = controller
    logic        wide;
    logic [23:0] addr;
    logic [24:0] rem;
    logic [7:0]  on_time;
    logic [7:0]  off_time;
    logic [7:0]  tcnt;
    logic        drq;
    logic        master_n;
    logic        memr_n;
    logic        memw_n;
    logic        sbhe_n;
    logic        oe_n;
    logic [15:0] hdata;
    logic        done;
    logic        scb_ack;
    logic [7:0]  scb_data;
    logic [7:0]  rdata;
  } fpd_dma_s;

  fpd_dma_s st_reg, st_next;

  logic [1:0]    push_n;
  logic [15:0]   push_data;
  logic [1:0]    pop_n;
  logic [15:0]   head;
  logic [LW-1:0] lvl;
  logic [LW-1:0] space;
  logic          loc_tick;
  logic          busy;
  logic          word_ok;
  logic [1:0]    step;

  // byte lane pick from a 24-bit value
  function automatic logic [7:0] fn_byte(input logic [23:0] v, input logic [1:0] idx);
    fn_byte = v[8*idx +: 8];
  endfunction

  fpd_fifo #(.DEPTH(FIFO_DEPTH)) u_fifo (
    .i_clk_sys   (i_clk_sys),
    .i_sys_rst   (i_sys_rst),
    .i_push_n    (push_n),
    .i_push_data (push_data),
    .i_pop_n     (pop_n),
    .o_head      (head),
    .o_level     (lvl)
  );

  fpd_clk_div #(.DIV(SCB_DIV)) u_div (
    .i_clk_sys  (i_clk_sys),
    .i_sys_rst  (i_sys_rst),
    .o_loc_clk  (o_loc_clk),
    .o_loc_tick (loc_tick)
  );

  // derived fifo and sizing terms
  assign space   = LVL_FULL - lvl;
  assign busy    = (st_reg.st != ST_IDLE);
  assign word_ok = st_reg.word_mode && !st_reg.addr[0] && (st_reg.rem >= 25'd2)
                   && (st_reg.dir ? (lvl >= LVL_TWO) : (space >= LVL_TWO));
  assign step    = st_reg.wide ? 2'd2 : 2'd1;

  // next state: register port, local strobes, host bus engine
  always_comb begin
    st_next         = st_reg;
    st_next.scb_ack = 1'b0;
    st_next.rdata   = '0;
    push_n          = 2'd0;
    push_data       = '0;
    pop_n           = 2'd0;

    // register writes; setup only while idle
    if (i_reg_wr) begin
      case (i_reg_addr)
        REG_CTRL: begin
          if (!busy) begin
            st_next.dir       = i_reg_wdata[CTRL_DIR];
            st_next.word_mode = i_reg_wdata[CTRL_WORD];
            st_next.src       = i_reg_wdata[CTRL_SRC];
            if (i_reg_wdata[CTRL_START]) begin
              st_next.st      = ST_WAIT;
              st_next.done    = 1'b0;
              st_next.rem[24] = (st_reg.rem[23:0] == 24'h000000);
            end
          end
        end
        REG_ADDR0: if (!busy) st_next.addr[7:0]   = i_reg_wdata;
        REG_ADDR1: if (!busy) st_next.addr[15:8]  = i_reg_wdata;
        REG_ADDR2: if (!busy) st_next.addr[23:16] = i_reg_wdata;
        REG_CNT0:  if (!busy) st_next.rem[7:0]    = i_reg_wdata;
        REG_CNT1:  if (!busy) st_next.rem[15:8]   = i_reg_wdata;
        REG_CNT2:  if (!busy) st_next.rem[23:16]  = i_reg_wdata;
        REG_ON:    if (!busy) st_next.on_time     = i_reg_wdata;
        REG_OFF:   if (!busy) st_next.off_time    = i_reg_wdata;
        REG_FIFO: begin
          if (busy && st_reg.src && st_reg.dir && (space != '0)) begin
            push_n    = 2'd1;
            push_data = {8'h00, i_reg_wdata};
          end
        end
        default: ;
      endcase
    end

    // register reads, data one cycle later
    if (i_reg_rd) begin
      case (i_reg_addr)
        REG_CTRL:  st_next.rdata = {4'h0, st_reg.src, st_reg.word_mode, st_reg.dir, busy};
        REG_ADDR0: st_next.rdata = fn_byte(st_reg.addr, 2'd0);
        REG_ADDR1: st_next.rdata = fn_byte(st_reg.addr, 2'd1);
        REG_ADDR2: st_next.rdata = fn_byte(st_reg.addr, 2'd2);
        REG_CNT0:  st_next.rdata = fn_byte(st_reg.rem[23:0], 2'd0);
        REG_CNT1:  st_next.rdata = fn_byte(st_reg.rem[23:0], 2'd1);
        REG_CNT2:  st_next.rdata = fn_byte(st_reg.rem[23:0], 2'd2);
        REG_ON:    st_next.rdata = st_reg.on_time;
        REG_OFF:   st_next.rdata = st_reg.off_time;
        REG_STAT:  st_next.rdata = {lvl, 1'b0, st_reg.done, busy};
        REG_FIFO: begin
          if (busy && st_reg.src && !st_reg.dir && (lvl != '0)) begin
            st_next.rdata = head[7:0];
            pop_n         = 2'd1;
          end
        end
        default: st_next.rdata = '0;
      endcase
    end

    // controller byte handshake, one ack per request
    if (busy && !st_reg.src && i_scb_req && !st_reg.scb_ack) begin
      if (st_reg.dir && (space != '0)) begin
        push_n          = 2'd1;
        push_data       = {8'h00, i_scb_data};
        st_next.scb_ack = 1'b1;
      end else if (!st_reg.dir && (lvl != '0)) begin
        pop_n            = 2'd1;
        st_next.scb_data = head[7:0];
        st_next.scb_ack  = 1'b1;
      end
    end

    // host bus engine
    case (st_reg.st)
      ST_IDLE: ;
      ST_WAIT: begin
        if (st_reg.rem == 25'd0) begin
          if (lvl == '0) begin
            st_next.st   = ST_IDLE;
            st_next.done = 1'b1;
          end
        end else if (st_reg.dir ? (lvl != '0) : (space != '0)) begin
          st_next.st  = ST_REQ;
          st_next.drq = 1'b1;
        end
      end
      ST_REQ: begin
        if (!i_host_dack_n) begin
          st_next.st       = ST_XFER;
          st_next.master_n = 1'b0;
          st_next.ph       = PH_SETUP;
          st_next.tcnt     = '0;
        end
      end
      ST_XFER: begin
        st_next.ph = st_reg.ph + 7'h01;
        if (loc_tick && (st_reg.tcnt != TCNT_MAX)) st_next.tcnt = st_reg.tcnt + 8'h01;
        if (st_reg.ph == PH_SETUP) begin
          st_next.wide   = word_ok;
          st_next.sbhe_n = ~(word_ok | st_reg.addr[0]);
          st_next.memw_n = ~st_reg.dir;
          st_next.memr_n = st_reg.dir;
          st_next.oe_n   = ~st_reg.dir;
          st_next.hdata  = word_ok ? head : {head[7:0], head[7:0]};
        end else if (st_reg.ph == PH_DONE) begin
          st_next.memw_n = 1'b1;
          st_next.memr_n = 1'b1;
          st_next.oe_n   = 1'b1;
          if (st_reg.dir) begin
            pop_n = step;
          end else begin
            push_n    = step;
            push_data = st_reg.wide ? i_host_data :
                        {8'h00, (st_reg.addr[0] ? i_host_data[15:8] : i_host_data[7:0])};
          end
          st_next.addr = st_reg.addr + 24'(step);
          st_next.rem  = st_reg.rem - 25'(step);
        end else if (st_reg.ph == PH_LAST) begin
          st_next.ph = PH_SETUP;
          if ((st_reg.rem == 25'd0) || (st_reg.tcnt >= st_reg.on_time)
              || (st_reg.dir ? (lvl == '0) : (space == '0))) begin
            st_next.drq      = 1'b0;
            st_next.master_n = 1'b1;
            st_next.sbhe_n   = 1'b1;
            st_next.tcnt     = '0;
            st_next.st       = (st_reg.rem == 25'd0) ? ST_WAIT : ST_OFF;
          end
        end
      end
      ST_OFF: begin
        if (loc_tick && (st_reg.tcnt != TCNT_MAX)) st_next.tcnt = st_reg.tcnt + 8'h01;
        if (st_reg.tcnt >= st_reg.off_time) st_next.st = ST_WAIT;
      end
      default: st_next.st = ST_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      st_reg          <= '0;
      st_reg.st       <= ST_IDLE;
      st_reg.on_time  <= RST_ON;
      st_reg.off_time <= RST_OFF;
      st_reg.master_n <= 1'b1;
      st_reg.memr_n   <= 1'b1;
      st_reg.memw_n   <= 1'b1;
      st_reg.sbhe_n   <= 1'b1;
      st_reg.oe_n     <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs straight from the state register
  assign o_reg_rdata      = st_reg.rdata;
  assign o_host_drq       = st_reg.drq;
  assign o_host_master_n  = st_reg.master_n;
  assign o_host_addr      = st_reg.addr;
  assign o_host_sbhe_n    = st_reg.sbhe_n;
  assign o_host_memr_n    = st_reg.memr_n;
  assign o_host_memw_n    = st_reg.memw_n;
  assign o_host_data      = st_reg.hdata;
  assign o_host_data_oe_n = st_reg.oe_n;
  assign o_scb_data       = st_reg.scb_data;
  assign o_scb_ack        = st_reg.scb_ack;

  // checks
  logic strb_n;
  assign strb_n = st_reg.memr_n & st_reg.memw_n;

  sequence s_strobe_start;
    $fell(strb_n);
  endsequence

  sequence s_strobe_end;
    $rose(strb_n);
  endsequence

  AST_REQ_NEEDS_DATA: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    ($rose(o_host_drq) && st_reg.dir) |-> ($past(lvl) != '0))
    else $error("request raised toward host with empty fifo");
  AST_MASTER_ON_GRANT: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    (st_reg.st == ST_REQ && !i_host_dack_n) |=> (!o_host_master_n && o_host_drq))
    else $error("master not asserted after grant");
  AST_WORD_SLOT: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    s_strobe_start |-> ##73 s_strobe_end)
    else $error("memory strobe width wrong");
  AST_ADDR_STEP: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    s_strobe_end |-> (o_host_addr == $past(o_host_addr) + 24'(step)))
    else $error("host address did not advance by transfer size");
  AST_WORD_EVEN: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    (!strb_n && st_reg.wide) |-> (!o_host_addr[0] && !o_host_sbhe_n))
    else $error("word cycle at odd address");
  AST_EMPTY_ENDS: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    (st_reg.st == ST_XFER && st_reg.ph == PH_LAST && st_reg.dir && lvl == '0)
    |=> (o_host_master_n && !o_host_drq))
    else $error("tenure kept with empty fifo");
  AST_FULL_ENDS: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    (st_reg.st == ST_XFER && st_reg.ph == PH_LAST && !st_reg.dir && space == '0)
    |=> o_host_master_n)
    else $error("tenure kept with full fifo");
  AST_OFF_HOLD: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    (st_reg.st == ST_OFF && st_reg.tcnt < st_reg.off_time) |=> (!o_host_drq && o_host_master_n))
    else $error("bus requested during off time");
  AST_DONE_CLEAN: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    $rose(st_reg.done) |-> (st_reg.rem == 25'd0 && lvl == '0))
    else $error("done flagged with data outstanding");
  AST_ACK_PULSE: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    o_scb_ack |=> !o_scb_ack)
    else $error("controller ack longer than one cycle");
  AST_LOC_PERIOD: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    $rose(o_loc_clk) |-> ##25 $fell(o_loc_clk) ##25 $rose(o_loc_clk))
    else $error("local clock not 250 ns");

endmodule // fpd_dma

`default_nettype wire

// file: bench/fpd_host_model.sv
`default_nettype none

module fpd_host_model (
  // clock and reset
  input  wire logic        i_clk_sys,
  input  wire logic        i_sys_rst,
  // grant pacing
  input  wire logic        i_slow,
  // host bus as seen from the engine
  input  wire logic        i_drq,
  output var  logic        o_dack_n,
  input  wire logic        i_master_n,
  input  wire logic [23:0] i_addr,
  input  wire logic        i_sbhe_n,
  input  wire logic        i_memr_n,
  input  wire logic        i_memw_n,
  input  wire logic        i_oe_n,
  input  wire logic [15:0] i_data,
  output var  logic [15:0] o_data,
  // tenure figures
  output var  logic [7:0]  o_slots,
  output var  logic [15:0] o_gap,
  output var  logic [7:0]  o_period
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]  mem [64];
  logic [7:0]  wcnt, slots, since;
  logic [15:0] gap;
  logic        strb_d, drq_d;
  wire  [5:0]  wa = i_addr[5:0];

  // grant after a short or long wait, held while requested
  always @(posedge i_clk_sys) begin
    wcnt <= (i_sys_rst || !i_drq) ? 8'h00 : wcnt + {7'h00, wcnt != 8'hFF};
  end
  assign o_dack_n = !(i_drq && wcnt >= (i_slow ? 8'h0C : 8'h01));

  // memory cycles; an idle bus shows a pattern that changes every cycle
  always @(posedge i_clk_sys) begin
    strb_d <= i_memr_n & i_memw_n;
    drq_d  <= i_drq;
    o_data <= i_sys_rst ? 16'h5A3C :
              !i_memr_n ? {mem[{wa[5:1], 1'b1}], mem[{wa[5:1], 1'b0}]} : ~o_data;
    // a write lands only while the engine drives the data lines
    if (!i_memw_n && !i_oe_n && !wa[0]) mem[wa] <= i_data[7:0];
    if (!i_memw_n && !i_oe_n && !i_sbhe_n) mem[{wa[5:1], 1'b1}] <= i_data[15:8];
  end

  // words per tenure, idle gap before a new request, slot period
  always @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      {slots, since, o_slots, o_period} <= 32'h0000_0000;
      gap   <= 16'hFFFF;
      o_gap <= 16'hFFFF;
    end else begin
      gap   <= i_master_n ? gap + {15'h0000, gap != 16'hFFFF} : 16'h0000;
      since <= since + {7'h00, since != 8'hFF};
      if (i_master_n) slots <= 8'h00;
      if (i_drq && !drq_d && gap < o_gap) o_gap <= gap;
      if (strb_d && !(i_memr_n && i_memw_n)) begin
        since <= 8'h00;
        slots <= slots + 8'h01;
        if (slots + 8'h01 > o_slots) o_slots <= slots + 8'h01;
        if (slots != 8'h00) o_period <= since + 8'h01;
      end
    end
  end
endmodule // fpd_host_model

`default_nettype wire

// file: bench/tb_fpd_dma.sv
`default_nettype none

module tb_fpd_dma;
  timeunit 1ns;
  timeprecision 1ps;
  import fpd_pkg::*;
  logic        i_clk_sys = 1'b0, i_sys_rst = 1'b1, i_reg_wr = 1'b0, i_reg_rd = 1'b0;
  logic [7:0]  i_reg_addr = 8'h00, i_reg_wdata = 8'h00, o_reg_rdata, i_scb_data = 8'h00;
  logic        i_scb_req = 1'b0, slow = 1'b0, feed = 1'b0, dack_n, drq, mst_n, sbhe_n;
  logic        memr_n, memw_n, oe_n, o_scb_ack, o_loc_clk, lc;
  logic [7:0]  o_scb_data, v, slots, period;
  logic [23:0] o_host_addr, a;
  logic [15:0] hd_in, hd_out, gap;
  logic [7:0]  src [64];
  logic [7:0]  orig [64];
  logic [7:0]  got [64];
  int          failures = 0, checks = 0, idx = 0, n = 0, hi = 0, rises = 0;
  logic [31:0] rs = 32'h0000_002F;

  always #2.5 i_clk_sys = ~i_clk_sys;

  fpd_dma dut (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_reg_addr(i_reg_addr),
    .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
    .o_reg_rdata(o_reg_rdata), .o_host_drq(drq), .i_host_dack_n(dack_n),
    .o_host_master_n(mst_n), .o_host_addr(o_host_addr), .o_host_sbhe_n(sbhe_n),
    .o_host_memr_n(memr_n), .o_host_memw_n(memw_n), .i_host_data(hd_in),
    .o_host_data(hd_out), .o_host_data_oe_n(oe_n), .i_scb_req(i_scb_req),
    .i_scb_data(i_scb_data), .o_scb_data(o_scb_data), .o_scb_ack(o_scb_ack),
    .o_loc_clk(o_loc_clk));

  fpd_host_model host (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_slow(slow),
    .i_drq(drq), .o_dack_n(dack_n), .i_master_n(mst_n), .i_addr(o_host_addr),
    .i_sbhe_n(sbhe_n), .i_memr_n(memr_n), .i_memw_n(memw_n), .i_oe_n(oe_n),
    .i_data(hd_out),
    .o_data(hd_in), .o_slots(slots), .o_gap(gap), .o_period(period));

  // xorshift source, fixed start
  function automatic logic [7:0] xs();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs[7:0];
  endfunction

  // controller byte side: feeds or collects bytes, stalling at random
  always @(posedge i_clk_sys) begin
    if (o_scb_ack === 1'b1) begin
      got[idx]   <= o_scb_data;
      i_scb_data <= src[idx + 1];
      idx        <= idx + 1;
      i_scb_req  <= 1'b0;
    end else begin
      i_scb_req <= feed && idx < n && xs() > 8'h50;
    end
  end

  task automatic give_verdict();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic check(string what, logic [23:0] seen, logic [23:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(logic [7:0] ad, logic [7:0] d);
    @(posedge i_clk_sys);
    i_reg_addr  <= ad;
    i_reg_wdata <= d;
    i_reg_wr    <= 1'b1;
    @(posedge i_clk_sys);
    i_reg_wr <= 1'b0;
  endtask

  task automatic rd(logic [7:0] ad, output logic [7:0] d);
    @(posedge i_clk_sys);
    i_reg_addr <= ad;
    i_reg_rd   <= 1'b1;
    @(posedge i_clk_sys);
    i_reg_rd <= 1'b0;
    #1 d = o_reg_rdata;
  endtask

  // every host byte: written inside the block, untouched outside it
  task automatic mem_check(logic [23:0] ad, int cnt);
    logic [5:0] o;
    for (int j = 0; j < 64; j++) begin
      o = 6'(j) - ad[5:0];
      check("host byte", host.mem[j], int'(o) < cnt ? src[o] : orig[j]);
    end
  endtask

  // one programmed transfer after a fresh reset
  task automatic xfer(logic [7:0] ctrl, logic [23:0] ad, int cnt, logic [7:0] on,
                      logic [7:0] off);
    logic [7:0] s;
    i_sys_rst <= 1'b1;
    repeat (6) @(posedge i_clk_sys);
    i_sys_rst <= 1'b0;
    for (int i = 0; i < 64; i++) begin
      src[i]      = xs();
      orig[i]     = xs();
      host.mem[i] = orig[i];
    end
    idx = 0;
    n   = cnt;
    i_scb_data <= src[0];
    wr(REG_ADDR0, ad[7:0]);
    wr(REG_ADDR1, ad[15:8]);
    wr(REG_ADDR2, ad[23:16]);
    wr(REG_CNT0, 8'(cnt));
    wr(REG_CNT1, 8'h00);
    wr(REG_CNT2, 8'h00);
    wr(REG_ON, on);
    wr(REG_OFF, off);
    wr(REG_CTRL, ctrl | 8'h01);
    repeat (100) @(posedge i_clk_sys);
    if (ctrl[CTRL_DIR]) check("early request", drq, 1'b0);
    feed <= !ctrl[CTRL_SRC];
    // processor side: write bytes in, or let the fifo fill and then read them out
    for (int i = 0; i < cnt && ctrl[CTRL_SRC]; i++) begin
      if (ctrl[CTRL_DIR]) begin
        wr(REG_FIFO, src[i]);
      end else begin
        if (i == 0) repeat (1000) @(posedge i_clk_sys);
        s = 8'h00;
        for (int k = 0; k < 1000 && s[7:3] == 5'h00; k++) rd(REG_STAT, s);
        rd(REG_FIFO, got[i]);
      end
    end
    s = 8'h00;
    for (int k = 0; k < 5000 && s !== 8'h02; k++) rd(REG_STAT, s);
    check("status", s, 8'h02);
    if (s !== 8'h02) give_verdict();
    feed <= 1'b0;
    rd(REG_CNT0, s);
    check("remaining", s, 8'h00);
    check("address", o_host_addr, ad + 24'(cnt));
    mem_check(ad, ctrl[CTRL_DIR] ? cnt : 0);
    for (int i = 0; i < cnt && !ctrl[CTRL_DIR]; i++) begin
      check("controller byte", got[i], orig[6'(ad[5:0] + 6'(i))]);
    end
  endtask

  // main sequence
  initial begin
    repeat (6) @(posedge i_clk_sys);
    i_sys_rst <= 1'b0;
    rd(REG_ON, v);
    check("on reset", v, RST_ON);
    rd(REG_OFF, v);
    check("off reset", v, RST_OFF);
    rd(REG_STAT, v);
    check("status reset", v, 8'h00);
    rd(8'h0F, v);
    check("unmapped", v, 8'h00);
    a = {16'h0000, xs()};
    wr(REG_ON, a[7:0]);
    rd(REG_ON, v);
    check("on time", v, a[7:0]);
    // local clock over a window of ten periods
    lc = o_loc_clk;
    for (int i = 0; i < 500; i++) begin
      @(posedge i_clk_sys);
      #1 hi += int'(o_loc_clk);
      rises += int'(o_loc_clk && !lc);
      lc = o_loc_clk;
    end
    check("local clock rises", 24'(rises), 24'(500 / (LOC_CLK_NS / CLK_NS)));
    check("local clock high", 24'(hi), 24'(250));
    // toward host from controller, odd start, one word per tenure
    xfer(8'h06, {xs(), xs(), xs() | 8'h01}, 7, 8'h00, 8'h02);
    check("words per tenure", slots, 8'h01);
    check("off gap", gap >= 16'(LOC_CLK_NS / CLK_NS), 1'b1);
    // from host into controller, slow grant, one long tenure
    slow <= 1'b1;
    xfer(8'h04, {xs(), xs(), xs() & 8'hFE}, 6, 8'h10, 8'h01);
    check("slot period", period, 8'(WORD_CLKS));
    check("words per tenure", slots, 8'h03);
    // processor bytes toward host, then controller bytes
    slow <= xs() > 8'h7F;
    xfer(8'h0A, {xs(), xs(), xs()}, 3, 8'h10, 8'h01);
    xfer(8'h02, {xs(), xs(), xs()}, 5, 8'h01, 8'h01);
    // from host into processor, drained late so the fifo fills and ends a tenure
    xfer(8'h0C, {xs(), xs(), xs() & 8'hFE}, 24, 8'hFF, 8'h01);
    check("words per tenure", slots, 8'(FIFO_BYTES / 2));
    give_verdict();
  end
endmodule // tb_fpd_dma

`default_nettype wire
